// ===== hw/epp_port_pkg.sv
/*
   Constants, register offsets, field positions and state codes for the
   parallel host port (EPP read cycle and extended register map).
   Assumes a 20 MHz core clock and an 11-bit host I/O offset from the port base.
*/
package epp_port_pkg;

   // clock and time base
   localparam int CLK_PERIOD_NS      = 50;
   localparam int EPP_TIMEOUT_NS     = 10000;
   localparam int EPP_TIMEOUT_CYCLES = EPP_TIMEOUT_NS / CLK_PERIOD_NS;

   // widths and sizes
   localparam int PORT_WORD_W   = 8;
   localparam int FIFO_DEPTH    = 16;
   localparam int IO_ADDR_W     = 11;
   localparam int RLE_MAX_RATIO = 64;

   // register offsets from the port base
   localparam logic [10:0] OFS_DATA      = 11'h000;
   localparam logic [10:0] OFS_STATUS    = 11'h001;
   localparam logic [10:0] OFS_CONTROL   = 11'h002;
   localparam logic [10:0] OFS_EPP_ADDR  = 11'h003;
   localparam logic [10:0] OFS_EPP_DATA0 = 11'h004;
   localparam logic [10:0] OFS_EPP_DATA3 = 11'h007;
   localparam logic [10:0] OFS_FIFO      = 11'h400;
   localparam logic [10:0] OFS_CONFIG_B  = 11'h401;
   localparam logic [10:0] OFS_EXT_CTRL  = 11'h402;

   // extended control mode field values
   localparam logic [2:0] MODE_STANDARD = 3'b000;
   localparam logic [2:0] MODE_BIDIR    = 3'b001;
   localparam logic [2:0] MODE_COMPAT   = 3'b010;
   localparam logic [2:0] MODE_ECP      = 3'b011;
   localparam logic [2:0] MODE_EPP      = 3'b100;
   localparam logic [2:0] MODE_TEST     = 3'b110;
   localparam logic [2:0] MODE_CONFIG   = 3'b111;

   // device control bit positions
   localparam int CTL_STROBE_BIT    = 0;
   localparam int CTL_AUTOFD_BIT    = 1;
   localparam int CTL_INIT_BIT      = 2;
   localparam int CTL_SELECTIN_BIT  = 3;
   localparam int CTL_ACKINTEN_BIT  = 4;
   localparam int CTL_DIRECTION_BIT = 5;
   localparam int CTL_W             = 6;

   // device status, extended control and Config B bit positions
   localparam int STS_TIMEOUT_BIT = 0;
   localparam int ECR_EMPTY_BIT   = 0;
   localparam int ECR_FULL_BIT    = 1;
   localparam int ECR_RW_LSB      = 2;
   localparam int ECR_MODE_LSB    = 5;
   localparam int CFGB_COMPRESS_BIT = 7;

   // reset and fixed values
   localparam logic [5:0] CTL_RESET        = 6'h00;
   localparam logic [5:0] ECR_RW_RESET     = 6'h00;
   localparam logic [7:0] CONFIG_A_VALUE   = 8'h10;
   localparam logic [7:0] TIMEOUT_READ_VAL = 8'hFF;
   localparam logic [7:0] UNMAPPED_VAL     = 8'hFF;

   typedef enum logic [1:0]
   {
      EPP_IDLE   = 2'b00,
      EPP_STROBE = 2'b01
   } epp_state_type;

endpackage

// ===== hw/shared_byte_fifo.sv
/*
   Common byte FIFO shared by the compatibility, ECP address, ECP data and
   test paths. First word falls through to the read side.
   Assumes a single clock and an asynchronous active-low reset already synchronised.
*/
`timescale 1ns/1ps
module shared_byte_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input  wire logic             i_clk,      // core clock
   input  wire logic             i_rst_n,    // synchronised reset, active low
   input  wire logic             i_flush,    // empties the FIFO
   input  wire logic             i_in_valid, // write request
   output logic                  o_in_ready, // space available
   input  wire logic [WIDTH-1:0] i_in_data,  // write data
   output logic                  o_out_valid,// data available
   input  wire logic             i_out_ready,// read request
   output logic [WIDTH-1:0]      o_out_data, // head of FIFO
   output logic                  o_full,     // FIFO full
   output logic                  o_empty     // FIFO empty
);

   localparam int PTR_W = $clog2(DEPTH);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wr_ptr;
      logic [PTR_W-1:0]            rd_ptr;
      logic [PTR_W:0]              count;
   } fifo_state_type;

   fifo_state_type s_q;
   fifo_state_type s_d;
   logic           push;
   logic           pop;

   assign o_full      = (s_q.count == (PTR_W+1)'(DEPTH));
   assign o_empty     = (s_q.count == '0);
   assign o_in_ready  = ~o_full;
   assign o_out_valid = ~o_empty;
   assign o_out_data  = s_q.mem[s_q.rd_ptr];

   always_comb
   begin
      s_d  = s_q;
      push = i_in_valid & ~o_full;
      pop  = i_out_ready & ~o_empty;
      if (push)
      begin
         s_d.mem[s_q.wr_ptr] = i_in_data;
         s_d.wr_ptr = s_q.wr_ptr + 1'b1;
      end
      if (pop)
         s_d.rd_ptr = s_q.rd_ptr + 1'b1;
      if (push & ~pop)
         s_d.count = s_q.count + 1'b1;
      else if (pop & ~push)
         s_d.count = s_q.count - 1'b1;
      if (i_flush)
      begin
         s_d.wr_ptr = '0;
         s_d.rd_ptr = '0;
         s_d.count  = '0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

endmodule

// ===== hw/epp_port_core.sv
/*
   Parallel host port: EPP 1.7 read cycle with wait-state stretching and
   time-out, standard control/status registers and the extended register map
   over one shared 16-byte FIFO.
   Assumes a host I/O request strobe of one cycle per access, held off while
   O_IO_WAIT is high; pins are synchronous to I_CLK.
*/
// Contract
// - Keep stretching read while wait input low
// - Assert data/address strobe once read starts
// - Hold read until wait negated or time-out
// - After wait negated: finish host read, drop strobe
// - Write-direction output is active low for writes
// - Interrupt input passed through, active high
// - Separate active-low data and address strobes
// - Active-low peripheral reset output provided
// - Only write-direction overridable by control port
// - Standard and EPP modes share one register
// - All FIFOs are one shared 16-byte FIFO
// - Status and control reachable in every mode
// - Config B reports configured interrupt and DMA
// - Port word fixed at eight bits
// - Optional run-length compression, up to 64:1; only the Config B compress bit is stored, no data is compressed
// - Abort cycles over 10 us, flag status bit 0
`timescale 1ns/1ps
module epp_port_core
   import epp_port_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = epp_port_pkg::EPP_TIMEOUT_CYCLES,
   parameter int FIFO_DEPTH_P   = epp_port_pkg::FIFO_DEPTH
)
(
   input  wire logic                                I_CLK,                      // 20 MHz clock
   input  wire logic                                I_RST_N,                    // async reset, low
   input  wire logic                                I_IO_RD,                    // host read pulse
   input  wire logic                                I_IO_WR,                    // host write pulse
   input  wire logic [epp_port_pkg::IO_ADDR_W-1:0]  I_IO_ADDR,                  // offset from base
   input  wire logic [epp_port_pkg::PORT_WORD_W-1:0] I_IO_WDATA,                // host write data
   output logic [epp_port_pkg::PORT_WORD_W-1:0]     O_IO_RDATA,                 // host read data
   output logic                                     O_IO_WAIT,                  // cycle stretched
   output logic                                     O_IO_DONE,                  // final sync pulse
   input  wire logic [epp_port_pkg::PORT_WORD_W-1:0] I_PORT_BYTE_BUS,           // byte bus in
   output logic [epp_port_pkg::PORT_WORD_W-1:0]     O_PORT_BYTE_BUS,            // byte bus out
   output logic                                     O_PORT_BYTE_BUS_OE,         // byte bus drive
   output logic                                     O_WRITE_DIRECTION_N,        // low = write
   output logic                                     O_DATA_PHASE_STROBE_N,      // data strobe
   output logic                                     O_ADDRESS_PHASE_STROBE_N,   // address strobe
   input  wire logic                                I_PERIPHERAL_WAIT_N,        // low = wait
   input  wire logic                                I_PERIPHERAL_INTERRUPT_IN,  // interrupt in
   output logic                                     O_PERIPHERAL_INTERRUPT,     // passed through
   output logic                                     O_PERIPHERAL_RESET_N,       // peripheral reset
   output logic                                     O_HOST_STROBE_N,            // control strobe
   output logic                                     O_AUTOFD_N,                 // control autofeed
   output logic                                     O_SELECTIN_N,               // control select in
   input  wire logic                                I_BUSY,                     // status busy
   input  wire logic                                I_ACK_N,                    // status ack
   input  wire logic                                I_PAPER_ERROR,              // status paper end
   input  wire logic                                I_SELECT,                   // status select
   input  wire logic                                I_FAULT_N,                  // status fault
   input  wire logic [2:0]                          I_CFG_IRQ_SEL,              // chosen interrupt
   input  wire logic [2:0]                          I_CFG_DMA_SEL               // chosen DMA channel
);

   localparam int TIMER_W = $clog2(TIMEOUT_CYCLES + 1);

   typedef struct packed
   {
      epp_state_type                   state;
      logic [TIMER_W-1:0]              timer;
      logic                            addr_phase;
      logic [PORT_WORD_W-1:0]          data_latch;
      logic [CTL_W-1:0]                ctl;
      logic [5:0]                      ecr_rw;
      logic                            compress;
      logic                            timeout;
      logic [PORT_WORD_W-1:0]          rdata;
      logic                            done;
      logic                            busy;
      logic                            dstb_n;
      logic                            astb_n;
      logic                            wdir_n;
      logic                            pd_oe;
      logic                            peripheral_interrupt_in;
      logic                            host_strobe_n;
      logic                            autofd_n;
      logic                            selectin_n;
      logic                            prst_n;
   } core_state_type;

   core_state_type         s_q;
   core_state_type         s_d;
   logic                   rst_meta_q;
   logic                   rst_sync_q;
   logic                   fifo_push;
   logic                   fifo_pop;
   logic                   fifo_flush;
   logic                   fifo_full;
   logic                   fifo_empty;
   logic [PORT_WORD_W-1:0] fifo_head;
   logic [2:0]             mode;
   logic [PORT_WORD_W-1:0] reg_rdata;

   // true for the four EPP data offsets and the EPP address offset
   function automatic logic is_epp_addr(input logic [IO_ADDR_W-1:0] a);
      is_epp_addr = (a == OFS_EPP_ADDR) || ((a >= OFS_EPP_DATA0) && (a <= OFS_EPP_DATA3));
   endfunction

   // reset release through two flip-flops
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign mode = s_q.ecr_rw[5:3];

   shared_byte_fifo
   #(
      .WIDTH (PORT_WORD_W),
      .DEPTH (FIFO_DEPTH_P)
   )
   u_fifo
   (
      .i_clk       (I_CLK),
      .i_rst_n     (rst_sync_q),
      .i_flush     (fifo_flush),
      .i_in_valid  (fifo_push),
      .o_in_ready  (),
      .i_in_data   (I_IO_WDATA),
      .o_out_valid (),
      .i_out_ready (fifo_pop),
      .o_out_data  (fifo_head),
      .o_full      (fifo_full),
      .o_empty     (fifo_empty)
   );

   // register read decode; status and control answer in every mode
   always_comb
   begin
      reg_rdata = UNMAPPED_VAL;
      case (I_IO_ADDR)
         OFS_DATA:
            if (s_q.ctl[CTL_DIRECTION_BIT])
               reg_rdata = I_PORT_BYTE_BUS;
            else
               reg_rdata = s_q.data_latch;
         OFS_STATUS:
            reg_rdata = {~I_BUSY, I_ACK_N, I_PAPER_ERROR, I_SELECT, I_FAULT_N,
                         2'b00, s_q.timeout};
         OFS_CONTROL:
            reg_rdata = {2'b00, s_q.ctl};
         OFS_FIFO:
            if (mode == MODE_CONFIG)
               reg_rdata = CONFIG_A_VALUE;
            else if ((mode == MODE_ECP) || (mode == MODE_TEST))
               reg_rdata = fifo_head;
         OFS_CONFIG_B:
            if (mode == MODE_CONFIG)
               reg_rdata = {s_q.compress, s_q.peripheral_interrupt_in, I_CFG_IRQ_SEL, I_CFG_DMA_SEL};
         OFS_EXT_CTRL:
            reg_rdata = {s_q.ecr_rw, fifo_full, fifo_empty};
         default:
            reg_rdata = UNMAPPED_VAL;
      endcase
   end

   always_comb
   begin
      s_d        = s_q;
      s_d.done   = 1'b0;
      fifo_push  = 1'b0;
      fifo_pop   = 1'b0;
      fifo_flush = 1'b0;
      s_d.peripheral_interrupt_in   = I_PERIPHERAL_INTERRUPT_IN;
      s_d.host_strobe_n = ~s_q.ctl[CTL_STROBE_BIT];
      s_d.autofd_n      = ~s_q.ctl[CTL_AUTOFD_BIT];
      s_d.selectin_n    = ~s_q.ctl[CTL_SELECTIN_BIT];
      s_d.prst_n        = s_q.ctl[CTL_INIT_BIT];
      case (s_q.state)
         EPP_IDLE:
         begin
            // outside a cycle both strobes stay high; write direction and bus drive follow the shared control register
            s_d.dstb_n = 1'b1;
            s_d.astb_n = 1'b1;
            s_d.wdir_n = s_q.ctl[CTL_DIRECTION_BIT]
                         & ~s_q.ctl[CTL_STROBE_BIT];
            s_d.pd_oe  = ~s_q.ctl[CTL_DIRECTION_BIT];
            if (I_IO_RD && (mode == MODE_EPP) && is_epp_addr(I_IO_ADDR))
            begin
               s_d.state      = EPP_STROBE;
               s_d.busy       = 1'b1;
               s_d.timer      = '0;
               s_d.pd_oe      = 1'b0;
               s_d.addr_phase = (I_IO_ADDR == OFS_EPP_ADDR);
               s_d.dstb_n     = (I_IO_ADDR == OFS_EPP_ADDR);
               s_d.astb_n     = (I_IO_ADDR != OFS_EPP_ADDR);
            end
            else if (I_IO_RD)
            begin
               s_d.done  = 1'b1;
               s_d.rdata = reg_rdata;
               if (I_IO_ADDR == OFS_STATUS)
                  s_d.timeout = 1'b0;
               if ((I_IO_ADDR == OFS_FIFO)
                   && ((mode == MODE_ECP) || (mode == MODE_TEST)))
                  fifo_pop = 1'b1;
            end
            else if (I_IO_WR)
            begin
               s_d.done = 1'b1;
               case (I_IO_ADDR)
                  OFS_DATA:
                     if (mode == MODE_ECP)
                        fifo_push = 1'b1;
                     else
                        s_d.data_latch = I_IO_WDATA;
                  OFS_CONTROL:
                     s_d.ctl = I_IO_WDATA[CTL_W-1:0];
                  OFS_FIFO:
                     if ((mode == MODE_COMPAT) || (mode == MODE_ECP)
                         || (mode == MODE_TEST))
                        fifo_push = 1'b1;
                  OFS_CONFIG_B:
                     if (mode == MODE_CONFIG)
                        s_d.compress = I_IO_WDATA[CFGB_COMPRESS_BIT];
                  OFS_EXT_CTRL:
                  begin
                     s_d.ecr_rw = I_IO_WDATA[7:ECR_RW_LSB];
                     if (I_IO_WDATA[7:ECR_MODE_LSB] != mode)
                        fifo_flush = 1'b1;
                  end
                  default:
                     s_d.done = 1'b1;
               endcase
            end
         end
         EPP_STROBE:
         begin
            s_d.timer = s_q.timer + 1'b1;
            if (I_PERIPHERAL_WAIT_N)
            begin
               // data valid: latch it, send the final sync, drop the strobe
               s_d.rdata  = I_PORT_BYTE_BUS;
               s_d.done   = 1'b1;
               s_d.busy   = 1'b0;
               s_d.dstb_n = 1'b1;
               s_d.astb_n = 1'b1;
               s_d.state  = EPP_IDLE;
            end
            else if (s_q.timer >= TIMER_W'(TIMEOUT_CYCLES - 1))
            begin
               s_d.timeout = 1'b1;
               s_d.rdata   = TIMEOUT_READ_VAL;
               s_d.done    = 1'b1;
               s_d.busy    = 1'b0;
               s_d.dstb_n  = 1'b1;
               s_d.astb_n  = 1'b1;
               s_d.state   = EPP_IDLE;
            end
            else
               s_d.busy = 1'b1;
         end
         default:
            s_d.state = EPP_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         s_q               <= '0;
         s_q.state         <= EPP_IDLE;
         s_q.ctl           <= CTL_RESET;
         s_q.ecr_rw        <= ECR_RW_RESET;
         s_q.dstb_n        <= 1'b1;
         s_q.astb_n        <= 1'b1;
         s_q.wdir_n        <= 1'b1;
         s_q.host_strobe_n <= 1'b1;
         s_q.autofd_n      <= 1'b1;
         s_q.selectin_n    <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   assign O_IO_RDATA               = s_q.rdata;
   assign O_IO_WAIT                = s_q.busy;
   assign O_IO_DONE                = s_q.done;
   assign O_PORT_BYTE_BUS          = s_q.data_latch;
   assign O_PORT_BYTE_BUS_OE       = s_q.pd_oe;
   assign O_WRITE_DIRECTION_N      = s_q.wdir_n;
   assign O_DATA_PHASE_STROBE_N    = s_q.dstb_n;
   assign O_ADDRESS_PHASE_STROBE_N = s_q.astb_n;
   assign O_PERIPHERAL_INTERRUPT   = s_q.peripheral_interrupt_in;
   assign O_PERIPHERAL_RESET_N     = s_q.prst_n;
   assign O_HOST_STROBE_N          = s_q.host_strobe_n;
   assign O_AUTOFD_N               = s_q.autofd_n;
   assign O_SELECTIN_N             = s_q.selectin_n;

endmodule

// ===== test/epp_port_properties.sv
/*
   Concurrent checks on the parallel host port: EPP read strobe, wait, time-out.
   Assumes the bench keeps read setup legal; the bind to epp_port_core stands at the end of this file.
*/
`timescale 1ns/1ps
module epp_port_properties
   import epp_port_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = 200
)
(
   input wire logic        I_CLK,
   input wire logic        I_RST_N,
   input wire logic        I_IO_RD,
   input wire logic        I_IO_WR,
   input wire logic [10:0] I_IO_ADDR,
   input wire logic [7:0]  I_PORT_BYTE_BUS,
   input wire logic        I_PERIPHERAL_WAIT_N,
   input wire logic        I_PERIPHERAL_INTERRUPT_IN,
   input wire logic [7:0]  O_IO_RDATA,
   input wire logic        O_IO_WAIT,
   input wire logic        O_IO_DONE,
   input wire logic        O_PORT_BYTE_BUS_OE,
   input wire logic        O_WRITE_DIRECTION_N,
   input wire logic        O_DATA_PHASE_STROBE_N,
   input wire logic        O_ADDRESS_PHASE_STROBE_N,
   input wire logic        O_PERIPHERAL_INTERRUPT
);
   logic        stb;
   logic [15:0] cnt_q;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   assign stb = !O_DATA_PHASE_STROBE_N || !O_ADDRESS_PHASE_STROBE_N;
   // strobe-low cycles of the running read
   always_ff @(posedge I_CLK or negedge I_RST_N)
      if (!I_RST_N)
         cnt_q <= 16'h0000;
      else
         cnt_q <= stb ? cnt_q + 16'h0001 : 16'h0000;
   sequence seq_sample;
      stb && I_PERIPHERAL_WAIT_N;
   endsequence
   sequence seq_finish;
      O_IO_DONE && !stb && !O_IO_WAIT && O_IO_RDATA == $past(I_PORT_BYTE_BUS);
   endsequence
   chk_wait_release: assert property (seq_sample |=> seq_finish)
      else $error("read did not finish after wait release");
   chk_wait_stretch: assert property (stb && !I_PERIPHERAL_WAIT_N &&
      cnt_q < TIMEOUT_CYCLES - 1 |=> stb && !O_IO_DONE)
      else $error("read ended while wait held");
   chk_timeout_abort: assert property (stb && !I_PERIPHERAL_WAIT_N &&
      cnt_q == TIMEOUT_CYCLES - 1 |=> O_IO_DONE && !stb && O_IO_RDATA == 8'hFF)
      else $error("time-out abort missing");
   chk_timeout_bound: assert property (cnt_q <= TIMEOUT_CYCLES)
      else $error("strobe held past time-out");
   chk_wait_level: assert property (O_IO_WAIT == stb)
      else $error("host wait differs from strobe");
   chk_bus_released: assert property (stb |-> !O_PORT_BYTE_BUS_OE && O_WRITE_DIRECTION_N)
      else $error("bus driven during read");
   chk_data_strobe: assert property ($fell(O_DATA_PHASE_STROBE_N) |-> O_ADDRESS_PHASE_STROBE_N &&
      $past(I_IO_RD) && $past(I_IO_ADDR) >= OFS_EPP_DATA0 && $past(I_IO_ADDR) <= OFS_EPP_DATA3)
      else $error("data strobe without data read");
   chk_addr_strobe: assert property ($fell(O_ADDRESS_PHASE_STROBE_N) |->
      O_DATA_PHASE_STROBE_N && $past(I_IO_RD) && $past(I_IO_ADDR) == OFS_EPP_ADDR)
      else $error("address strobe without address read");
   chk_reg_answer: assert property ((I_IO_RD || I_IO_WR) && !stb && !O_IO_DONE &&
      (I_IO_ADDR < OFS_EPP_ADDR || I_IO_ADDR > OFS_EPP_DATA3) |=> O_IO_DONE)
      else $error("register access not answered");
   chk_irq_pass: assert property (O_PERIPHERAL_INTERRUPT == $past(I_PERIPHERAL_INTERRUPT_IN))
      else $error("interrupt not passed through");
endmodule
bind epp_port_core epp_port_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) epp_port_properties_i (
   .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_IO_RD(I_IO_RD), .I_IO_WR(I_IO_WR),
   .I_IO_ADDR(I_IO_ADDR), .I_PORT_BYTE_BUS(I_PORT_BYTE_BUS),
   .I_PERIPHERAL_WAIT_N(I_PERIPHERAL_WAIT_N), .I_PERIPHERAL_INTERRUPT_IN(I_PERIPHERAL_INTERRUPT_IN),
   .O_IO_RDATA(O_IO_RDATA), .O_IO_WAIT(O_IO_WAIT), .O_IO_DONE(O_IO_DONE),
   .O_PORT_BYTE_BUS_OE(O_PORT_BYTE_BUS_OE), .O_WRITE_DIRECTION_N(O_WRITE_DIRECTION_N),
   .O_DATA_PHASE_STROBE_N(O_DATA_PHASE_STROBE_N),
   .O_ADDRESS_PHASE_STROBE_N(O_ADDRESS_PHASE_STROBE_N),
   .O_PERIPHERAL_INTERRUPT(O_PERIPHERAL_INTERRUPT));

// ===== test/epp_peripheral_model.sv
/*
   EPP peripheral answering reads: wait low while busy, data then wait high.
   Assumes strobes come from the port; the bench resolves the byte bus.
*/
`timescale 1ns/1ps
module epp_peripheral_model
(
   input  wire logic       i_clk,       // port clock
   input  wire logic       i_data_stb_n, // data strobe
   input  wire logic       i_addr_stb_n, // address strobe
   input  wire logic [3:0] i_delay,     // wait cycles before data
   input  wire logic [7:0] i_byte,      // byte to return
   input  wire logic       i_hang,      // never release wait
   output logic            o_wait_n,    // wait line
   output logic [7:0]      o_bus        // byte bus drive
);
   logic [3:0] cnt;
   logic [7:0] last;
   initial
   begin
      cnt = 4'h0;
      last = 8'h00;
      o_wait_n = 1'b0;
      o_bus = 8'hFF;
   end
   always @(posedge i_clk)
      if (i_data_stb_n && i_addr_stb_n)
      begin
         cnt <= 4'h0;
         o_wait_n <= 1'b0;
         o_bus <= ~last;
      end
      else
      begin
         cnt <= cnt + 4'h1;
         if (cnt >= i_delay)
         begin
            o_bus <= i_byte;
            last <= i_byte;
         end
         if (cnt > i_delay && !i_hang)
            o_wait_n <= 1'b1;
      end
endmodule

// ===== test/testbench.sv
/*
   Self-checking bench for epp_port_core with a short time-out.
   Assumes the bound checker and the peripheral model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
   import epp_port_pkg::*;
   localparam int TO = 10;
   logic        clk, rst_n, rd, wr, irq_in, hang, io_wait, io_done, oe, wdir_n;
   logic        dstb_n, astb_n, irq_out, prst_n, hstb_n, afd_n, sel_n, per_wait_n;
   logic [10:0] addr;
   logic [7:0]  wdata, pbyte, bus_in, bus_out, per_bus, io_rdata, rdata;
   logic [3:0]  dly;
   logic [4:0]  sts;
   logic [2:0]  irq_sel, dma_sel;
   int          n_mismatch, cmp_count;
   assign bus_in = oe ? bus_out : per_bus;
   epp_port_core #(.TIMEOUT_CYCLES(TO)) epp_port_core_i (
      .I_CLK(clk), .I_RST_N(rst_n), .I_IO_RD(rd), .I_IO_WR(wr), .I_IO_ADDR(addr),
      .I_IO_WDATA(wdata), .O_IO_RDATA(io_rdata), .O_IO_WAIT(io_wait), .O_IO_DONE(io_done),
      .I_PORT_BYTE_BUS(bus_in), .O_PORT_BYTE_BUS(bus_out), .O_PORT_BYTE_BUS_OE(oe),
      .O_WRITE_DIRECTION_N(wdir_n), .O_DATA_PHASE_STROBE_N(dstb_n),
      .O_ADDRESS_PHASE_STROBE_N(astb_n), .I_PERIPHERAL_WAIT_N(per_wait_n),
      .I_PERIPHERAL_INTERRUPT_IN(irq_in), .O_PERIPHERAL_INTERRUPT(irq_out),
      .O_PERIPHERAL_RESET_N(prst_n), .O_HOST_STROBE_N(hstb_n), .O_AUTOFD_N(afd_n),
      .O_SELECTIN_N(sel_n), .I_BUSY(sts[4]), .I_ACK_N(sts[3]), .I_PAPER_ERROR(sts[2]),
      .I_SELECT(sts[1]), .I_FAULT_N(sts[0]), .I_CFG_IRQ_SEL(irq_sel), .I_CFG_DMA_SEL(dma_sel));
   epp_peripheral_model epp_peripheral_model_i (
      .i_clk(clk), .i_data_stb_n(dstb_n), .i_addr_stb_n(astb_n), .i_delay(dly),
      .i_byte(pbyte), .i_hang(hang), .o_wait_n(per_wait_n), .o_bus(per_bus));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task final_report;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task acc(input logic r, input logic [10:0] a, input logic [7:0] d);
      int i;
      @(negedge clk);
      rd = r;
      wr = !r;
      addr = a;
      wdata = d;
      @(negedge clk);
      rd = 1'b0;
      wr = 1'b0;
      for (i = 0; i < TO + 5 && io_done !== 1'b1; i++)
         @(negedge clk);
      chk({7'h00, io_done}, 8'h01);
      if (io_done !== 1'b1)
         final_report();
      rdata = io_rdata;
   endtask
   task t_reset;
      chk({7'h00, prst_n}, 8'h00);
      acc(1'b1, OFS_CONTROL, 8'h00);
      chk(rdata, 8'h00);
   endtask
   task t_control;
      acc(1'b0, OFS_CONTROL, 8'h0F);
      @(negedge clk);
      chk({4'h0, wdir_n, hstb_n, afd_n, sel_n}, 8'h00);
      acc(1'b0, OFS_DATA, 8'h5A);
      chk(bus_out, 8'h5A);
      chk({7'h00, oe}, 8'h01);
      acc(1'b0, OFS_CONTROL, 8'h24);
      @(negedge clk);
      chk({2'h0, hstb_n, afd_n, sel_n, prst_n, oe, wdir_n}, 8'h3D);
   endtask
   task t_epp;
      int i;
      acc(1'b0, OFS_EXT_CTRL, 8'h80);
      for (i = 0; i < 3; i++)
      begin
         dly = 4'(i * 2);
         pbyte = 8'hA5 ^ 8'(i);
         acc(1'b1, (i == 2) ? OFS_EPP_ADDR : OFS_EPP_DATA0 + 11'(i * 3), 8'h00);
         chk(rdata, pbyte);
      end
   endtask
   task t_timeout;
      hang = 1'b1;
      acc(1'b1, OFS_EPP_DATA0, 8'h00);
      chk(rdata, TIMEOUT_READ_VAL);
      hang = 1'b0;
      acc(1'b1, OFS_STATUS, 8'h00);
      chk(rdata, 8'h29);
      acc(1'b1, OFS_STATUS, 8'h00);
      chk(rdata, 8'h28);
   endtask
   task t_cfg;
      irq_sel = 3'h5;
      dma_sel = 3'h3;
      acc(1'b0, OFS_EXT_CTRL, 8'hE0);
      acc(1'b1, OFS_FIFO, 8'h00);
      chk(rdata, CONFIG_A_VALUE);
      acc(1'b1, OFS_CONFIG_B, 8'h00);
      chk(rdata & 8'h3F, 8'h2B);
      acc(1'b0, OFS_CONFIG_B, 8'h80);
      acc(1'b1, OFS_CONFIG_B, 8'h00);
      chk(rdata & 8'h80, 8'h80);
      acc(1'b1, 11'h010, 8'h00);
      chk(rdata, UNMAPPED_VAL);
      irq_in = 1'b1;
      repeat (2) @(negedge clk);
      chk({7'h00, irq_out}, 8'h01);
   endtask
   task t_fifo;
      int i;
      acc(1'b0, OFS_EXT_CTRL, 8'hC0);
      for (i = 0; i < 17; i++)
         acc(1'b0, OFS_FIFO, 8'(i));
      acc(1'b1, OFS_EXT_CTRL, 8'h00);
      chk(rdata, 8'hC2);
      for (i = 0; i < 16; i++)
      begin
         acc(1'b1, OFS_FIFO, 8'h00);
         chk(rdata, 8'(i));
      end
      acc(1'b1, OFS_EXT_CTRL, 8'h00);
      chk(rdata, 8'hC1);
      acc(1'b0, OFS_EXT_CTRL, 8'h40);
      acc(1'b0, OFS_FIFO, 8'h11);
      acc(1'b1, OFS_EXT_CTRL, 8'h00);
      chk(rdata, 8'h40);
      acc(1'b0, OFS_EXT_CTRL, 8'h60);
      acc(1'b0, OFS_DATA, 8'h3C);
      acc(1'b1, OFS_FIFO, 8'h00);
      chk(rdata, 8'h3C);
      acc(1'b1, OFS_CONTROL, 8'h00);
      chk(rdata, 8'h24);
   endtask
   initial
   begin
      rst_n = 1'b0;
      {rd, wr, irq_in, hang} = 4'h0;
      addr = 11'h000;
      {wdata, pbyte, rdata} = 24'h000000;
      dly = 4'h0;
      sts = 5'h15;
      {irq_sel, dma_sel} = 6'h00;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_reset();
      t_control();
      t_epp();
      t_timeout();
      t_cfg();
      t_fifo();
      final_report();
   end
endmodule
